// [monitor_defines.svh]
`ifndef MONITOR_DEFINES_SVH
`define MONITOR_DEFINES_SVH

`define REG_MON_CTRL 12'h270
`define REG_PERIOD_LOW 12'h271
`define REG_PERIOD_MID 12'h272
`define REG_PERIOD_HIGH 12'h273
`define REG_RESULT_CTRL 12'h274
`define REG_RESULT_LOW 12'h275
`define REG_RESULT_MID 12'h276
`define REG_RESULT_HIGH 12'h277
`define REG_PERIOD_COUNT 12'h278
`define REG_LINK_OUT_CTRL 12'h279
`define REG_LINK_IN_SEL 12'h27a

`define RST_MON_CTRL 8'h00
`define RST_PERIOD_LOW 8'h80
`define RST_PERIOD_MID 8'h00
`define RST_PERIOD_HIGH 8'h00
`define RST_RESULT_CTRL 8'h01
`define RST_LINK_OUT_CTRL 8'h00
`define RST_LINK_IN_SEL 8'h00

`define BIT_PEAK_EN 1
`define BIT_UPDATE 4
`define BIT_SELECT 0
`define BIT_LINK_PEAK 1
`define BIT_LINK_EN 0

`define SAMPLE_W 14
`define PEAK_W 13
`define RESULT_W 20
`define PEAK_LSB 7
`define PERIOD_W 24
`define RESULT_MID_LSB 8
`define RESULT_HIGH_LSB 16

`endif

// [monitor_pkg.sv]
package monitor_pkg;
  typedef enum logic [1:0] {
    bus_idle = 2'b00,
    bus_ack = 2'b01
  } bus_state_e;
  typedef logic [7:0] byte_t;
endpackage

// [peak_tracker.sv]
`include "monitor_defines.svh"

module peak_tracker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic enable_i,
  input wire logic [`PERIOD_W-1:0] period_i,
  // Samples, signed two's complement
  input wire logic [`SAMPLE_W-1:0] sample_i,
  // Results
  output logic [`PEAK_W-1:0] peak_o,
  output logic [`PEAK_W-1:0] last_peak_o,
  output logic [`PERIOD_W-1:0] count_o,
  output logic period_done_o
);
  logic [`PEAK_W-1:0] next_peak;
  logic [`PEAK_W-1:0] next_last_peak;
  logic [`PERIOD_W-1:0] next_count;
  logic next_done;
  logic [`PEAK_W-1:0] mag;

  // Magnitude saturates so the most negative code fits 13 bits
  function automatic logic [`PEAK_W-1:0] magnitude(input logic [`SAMPLE_W-1:0] s);
    logic [`SAMPLE_W-1:0] a;
    a = s[`SAMPLE_W-1] ? (~s + `SAMPLE_W'h1) : s;
    magnitude = a[`SAMPLE_W-1] ? {`PEAK_W{1'b1}} : a[`PEAK_W-1:0];
  endfunction

  always_comb begin
    mag = magnitude(sample_i);
    next_peak = peak_o;
    next_last_peak = last_peak_o;
    next_count = count_o;
    next_done = 1'b0;
    if (!enable_i) begin
      next_peak = '0;
      next_count = '0;
    end else if (count_o + `PERIOD_W'h1 >= period_i) begin
      next_last_peak = (mag > peak_o) ? mag : peak_o;
      next_peak = '0;
      next_count = '0;
      next_done = 1'b1;
    end else begin
      next_count = count_o + `PERIOD_W'h1;
      if (mag > peak_o) begin
        next_peak = mag;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      peak_o <= '0;
      last_peak_o <= '0;
      count_o <= '0;
      period_done_o <= 1'b0;
    end else begin
      peak_o <= next_peak;
      last_peak_o <= next_last_peak;
      count_o <= next_count;
      period_done_o <= next_done;
    end
  end
endmodule // peak_tracker

// [signal_monitor_peak_detector.sv]
`include "monitor_defines.svh"

module signal_monitor_peak_detector (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [11:0] adr_i,
  input wire logic [0:0] sel_i,
  input wire logic [7:0] dat_i,
  output logic [7:0] dat_o,
  output logic ack_o,
  // Converter samples on the same clock
  input wire logic [`SAMPLE_W-1:0] sample_i,
  // Serial port link feed
  output logic [`RESULT_W-1:0] link_result_o,
  output logic link_valid_o
);
  monitor_pkg::bus_state_e state, next_state;
  monitor_pkg::byte_t mon_ctrl, next_mon_ctrl;
  monitor_pkg::byte_t period_low, next_period_low;
  monitor_pkg::byte_t period_mid, next_period_mid;
  monitor_pkg::byte_t period_high, next_period_high;
  monitor_pkg::byte_t result_ctrl, next_result_ctrl;
  monitor_pkg::byte_t link_out_ctrl, next_link_out_ctrl;
  monitor_pkg::byte_t link_in_sel, next_link_in_sel;
  logic [`RESULT_W-1:0] result, next_result;
  monitor_pkg::byte_t count_result, next_count_result;
  logic [7:0] next_dat;
  logic next_ack;
  logic [`RESULT_W-1:0] next_link_result;
  logic next_link_valid;
  logic [`PEAK_W-1:0] peak_now;
  logic [`PEAK_W-1:0] peak_last;
  logic [`PERIOD_W-1:0] count_now;
  logic period_done;
  logic wr;

  // Peak placed in the upper result bits
  function automatic logic [`RESULT_W-1:0] pack_peak(input logic [`PEAK_W-1:0] p);
    pack_peak = {p, {`PEAK_LSB{1'b0}}};
  endfunction

  peak_tracker tracker (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enable_i(mon_ctrl[`BIT_PEAK_EN]),
    .period_i({period_high, period_mid, period_low}),
    .sample_i(sample_i),
    .peak_o(peak_now),
    .last_peak_o(peak_last),
    .count_o(count_now),
    .period_done_o(period_done)
  );

  // One-cycle ack; no wait states
  always_comb begin
    next_state = monitor_pkg::bus_idle;
    next_ack = 1'b0;
    wr = 1'b0;
    case (state)
      monitor_pkg::bus_idle: begin
        if (cyc_i && stb_i) begin
          next_state = monitor_pkg::bus_ack;
          next_ack = 1'b1;
          wr = we_i && sel_i[0];
        end
      end
      monitor_pkg::bus_ack: next_state = monitor_pkg::bus_idle;
      default: next_state = monitor_pkg::bus_idle;
    endcase
  end

  always_comb begin
    next_mon_ctrl = mon_ctrl;
    next_period_low = period_low;
    next_period_mid = period_mid;
    next_period_high = period_high;
    next_result_ctrl = result_ctrl;
    next_link_out_ctrl = link_out_ctrl;
    next_link_in_sel = link_in_sel;
    next_result = result;
    next_count_result = count_result;
    // Update bit clears itself on the same edge as the copy
    next_result_ctrl[`BIT_UPDATE] = 1'b0;
    if (result_ctrl[`BIT_UPDATE] && result_ctrl[`BIT_SELECT]) begin
      next_result = pack_peak(peak_last);
      next_count_result = monitor_pkg::byte_t'(count_now);
    end
    if (wr) begin
      case (adr_i)
        `REG_MON_CTRL: next_mon_ctrl = dat_i & (8'h1 << `BIT_PEAK_EN);
        `REG_PERIOD_LOW: next_period_low = dat_i;
        `REG_PERIOD_MID: next_period_mid = dat_i;
        `REG_PERIOD_HIGH: next_period_high = dat_i;
        `REG_RESULT_CTRL: begin
          next_result_ctrl = dat_i & ((8'h1 << `BIT_UPDATE) | (8'h1 << `BIT_SELECT));
        end
        `REG_LINK_OUT_CTRL: next_link_out_ctrl = dat_i & (8'h1 << `BIT_LINK_EN);
        `REG_LINK_IN_SEL: next_link_in_sel = dat_i & (8'h1 << `BIT_LINK_PEAK);
        default: next_mon_ctrl = mon_ctrl;
      endcase
    end
  end

  always_comb begin
    next_dat = 8'h00;
    if (state == monitor_pkg::bus_idle && cyc_i && stb_i && !we_i) begin
      case (adr_i)
        `REG_MON_CTRL: next_dat = mon_ctrl;
        `REG_PERIOD_LOW: next_dat = period_low;
        `REG_PERIOD_MID: next_dat = period_mid;
        `REG_PERIOD_HIGH: next_dat = period_high;
        `REG_RESULT_CTRL: next_dat = result_ctrl;
        `REG_RESULT_LOW: next_dat = monitor_pkg::byte_t'(result);
        `REG_RESULT_MID: next_dat = monitor_pkg::byte_t'(result >> `RESULT_MID_LSB);
        // Upper nibble reads zero: only four result bits remain after the shift
        `REG_RESULT_HIGH: next_dat = monitor_pkg::byte_t'(result >> `RESULT_HIGH_LSB);
        `REG_PERIOD_COUNT: next_dat = count_result;
        `REG_LINK_OUT_CTRL: next_dat = link_out_ctrl;
        `REG_LINK_IN_SEL: next_dat = link_in_sel;
        default: next_dat = 8'h00;
      endcase
    end
  end

  // Link carries each completed period's peak while routed and enabled
  always_comb begin
    next_link_valid = 1'b0;
    next_link_result = link_result_o;
    if (link_in_sel[`BIT_LINK_PEAK] && link_out_ctrl[`BIT_LINK_EN] && period_done) begin
      next_link_valid = 1'b1;
      next_link_result = pack_peak(peak_last);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= monitor_pkg::bus_idle;
      ack_o <= 1'b0;
      dat_o <= 8'h00;
      mon_ctrl <= `RST_MON_CTRL;
      period_low <= `RST_PERIOD_LOW;
      period_mid <= `RST_PERIOD_MID;
      period_high <= `RST_PERIOD_HIGH;
      result_ctrl <= `RST_RESULT_CTRL;
      link_out_ctrl <= `RST_LINK_OUT_CTRL;
      link_in_sel <= `RST_LINK_IN_SEL;
      result <= '0;
      count_result <= 8'h00;
      link_result_o <= '0;
      link_valid_o <= 1'b0;
    end else begin
      state <= next_state;
      ack_o <= next_ack;
      dat_o <= next_dat;
      mon_ctrl <= next_mon_ctrl;
      period_low <= next_period_low;
      period_mid <= next_period_mid;
      period_high <= next_period_high;
      result_ctrl <= next_result_ctrl;
      link_out_ctrl <= next_link_out_ctrl;
      link_in_sel <= next_link_in_sel;
      result <= next_result;
      count_result <= next_count_result;
      link_result_o <= next_link_result;
      link_valid_o <= next_link_valid;
    end
  end
endmodule // signal_monitor_peak_detector

// [signal_monitor_peak_detector_monitor.sv]
`include "monitor_defines.svh"

module signal_monitor_peak_detector_monitor (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [11:0] adr_i,
  input wire logic [7:0] dat_o,
  input wire logic ack_o,
  // Link feed
  input wire logic [`RESULT_W-1:0] link_result_o,
  input wire logic link_valid_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic rd_ack = ack_o && !we_i;

  a_ack_follows_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
  a_ack_one_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
  a_idle_data_zero: assert property (!ack_o |-> dat_o == 8'h00) else $error("idle data");
  a_update_self_clear: assert property (rd_ack && adr_i == 12'h274 |-> dat_o[7:1] == 7'h00)
    else $error("update bit stuck");
  a_result_low_zero: assert property (rd_ack && adr_i == 12'h275 |-> dat_o[6:0] == 7'h00)
    else $error("result low bits");
  a_result_high_zero: assert property (rd_ack && adr_i == 12'h277 |-> dat_o[7:4] == 4'h0)
    else $error("result high bits");
  a_link_low_zero: assert property (link_valid_o |-> link_result_o[6:0] == 7'h00)
    else $error("link low bits");
  a_enable_bits_only: assert property (rd_ack && (adr_i == 12'h270 || adr_i == 12'h27a)
    |-> (dat_o & 8'hfd) == 8'h00) else $error("enable reserved bits");

  c_link_feed: cover property (link_valid_o);
  c_update: cover property (ack_o && we_i && adr_i == 12'h274);
  c_result_read: cover property (rd_ack && adr_i == 12'h275);
endmodule // signal_monitor_peak_detector_monitor

bind signal_monitor_peak_detector signal_monitor_peak_detector_monitor u_mon (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .dat_o(dat_o), .ack_o(ack_o), .link_result_o(link_result_o), .link_valid_o(link_valid_o)
);

// [signal_monitor_peak_detector_tb.sv]
`include "monitor_defines.svh"

module signal_monitor_peak_detector_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int P = 20;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, link_valid_o;
  logic [0:0] sel_i;
  logic [11:0] adr_i;
  logic [7:0] dat_i, dat_o, q;
  logic [13:0] sample_i, mag;
  logic [19:0] link_result_o, res, expv;
  logic [31:0] seed = 32'ha000b141, rnd = 32'ha000b141;
  int errors = 0, comparisons = 0, pulses = 0, n;
  logic [7:0] rst_tab [12] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00};
  logic [7:0] rw_tab [12] = '{8'h02, 8'hff, 8'hff, 8'hff, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h01, 8'h02, 8'h00};

  signal_monitor_peak_detector dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .sample_i(sample_i),
    .link_result_o(link_result_o), .link_valid_o(link_valid_o)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Most negative sample saturates
  function automatic logic [19:0] exp_res(input logic [13:0] m);
    return {(m == 14'h2000) ? 13'h1fff : m[12:0], 7'h00};
  endfunction

  // Period values 0 and 1 both end every cycle
  function automatic int exp_gap(input logic [23:0] p);
    return (p < 24'h000002) ? 1 : int'(p);
  endfunction

  // First pulse may close a period cut short by a reprogram, so time the one after
  task automatic gap(output int g);
    g = 0;
    while (link_valid_o !== 1'b1 && g < 1000) begin
      @(posedge clk_i);
      g++;
    end
    g = 0;
    do begin
      @(posedge clk_i);
      g++;
    end while (link_valid_o !== 1'b1 && g < 1000);
  endtask

  task automatic end_sim();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d,
      output logic [7:0] r);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd_res(output logic [19:0] r);
    logic [7:0] a, b, c;
    bus(1'b0, 12'h275, 8'h00, a);
    bus(1'b0, 12'h276, 8'h00, b);
    bus(1'b0, 12'h277, 8'h00, c);
    r = {c[3:0], b, a};
  endtask

  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    seed <= lfsr(seed);
    sample_i <= seed[0] ? -mag : mag;
  end
  always @(posedge clk_i) if (link_valid_o === 1'b1) pulses <= pulses + 1;

  initial begin
    repeat (5000) @(posedge clk_i);
    errors++;
    end_sim();
  end

  initial begin
    {clk_i, cyc_i, stb_i, we_i, adr_i, dat_i, mag, sample_i} = '0;
    rst_i = 1'b1;
    sel_i = 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 12; i++) begin
      bus(1'b0, 12'h270 + 12'(i), 8'h00, q);
      chk("reset", 20'(rst_tab[i]), 20'(q));
    end
    // Descending so the update fires before the detector is enabled
    for (int i = 11; i >= 0; i--) bus(1'b1, 12'h270 + 12'(i), 8'hff, q);
    for (int i = 0; i < 12; i++) begin
      bus(1'b0, 12'h270 + 12'(i), 8'h00, q);
      chk("access", 20'(rw_tab[i]), 20'(q));
    end
    bus(1'b1, 12'h271, 8'(P), q);
    bus(1'b1, 12'h272, 8'h00, q);
    bus(1'b1, 12'h273, 8'h00, q);
    bus(1'b1, 12'h27a, 8'h00, q);
    for (int k = 0; k < 6; k++) begin
      rnd = lfsr(rnd);
      mag <= (k == 0) ? 14'h2000 : (k == 1) ? 14'h1fff : {1'b0, rnd[12:0]};
      repeat (3 * P) @(posedge clk_i);
      bus(1'b1, 12'h274, 8'h11, q);
      rd_res(res);
      expv = exp_res(mag);
      chk("result", expv, res);
    end
    mag <= 14'h0005;
    repeat (3 * P) @(posedge clk_i);
    // Select stays at the peak detector; zero is reserved
    bus(1'b1, 12'h274, 8'h01, q);
    rd_res(res);
    chk("held", expv, res);
    bus(1'b1, 12'h27a, 8'h02, q);
    n = 0;
    while (link_valid_o !== 1'b1 && n < 4 * P) begin
      @(posedge clk_i);
      n++;
    end
    chk("link", exp_res(mag), link_result_o);
    for (int j = 0; j < 2; j++) begin
      bus(1'b1, 12'h272, 8'(j), q);
      gap(n);
      gap(n);
      chk("gap", 20'(exp_gap({8'h00, 8'(j), 8'(P)})), 20'(n));
    end
    bus(1'b1, 12'h272, 8'h00, q);
    for (int j = 0; j < 2; j++) begin
      bus(1'b1, j ? 12'h270 : 12'h27a, j ? 8'h00 : 8'h00, q);
      if (j) bus(1'b1, 12'h27a, 8'h02, q);
      repeat (2) @(posedge clk_i);
      n = pulses;
      repeat (3 * P) @(posedge clk_i);
      chk("quiet", 20'(n), 20'(pulses));
    end
    end_sim();
  end
endmodule // signal_monitor_peak_detector_tb
